/* shared/wwd_pkg.sv */
/*
 * Constants shared by the windowed watchdog: register byte addresses, field
 * positions, reset values, feed keys and timing counts.
 * Assumes a 200 MHz peripheral clock and a 32-bit classic Wishbone bus.
 */
package wwd_pkg;

    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned CNT_W         = 24;
    localparam int unsigned WARN_W        = 10;

    // Register byte addresses.
    localparam logic [31:0] ADR_MODE      = 32'h4000_4000;
    localparam logic [31:0] ADR_TC        = 32'h4000_4004;
    localparam logic [31:0] ADR_FEED      = 32'h4000_4008;
    localparam logic [31:0] ADR_VALUE     = 32'h4000_400C;
    localparam logic [31:0] ADR_TICK_SOURCE_SELECT    = 32'h4000_4010;
    localparam logic [31:0] ADR_WARN      = 32'h4000_4014;
    localparam logic [31:0] ADR_WINDOW    = 32'h4000_4018;

    // Mode register fields.
    localparam int unsigned MODE_RUN_BIT  = 0;
    localparam int unsigned MODE_RST_BIT  = 1;
    localparam int unsigned MODE_TOF_BIT  = 2;
    localparam int unsigned MODE_WINT_BIT = 3;
    localparam int unsigned MODE_PROT_BIT = 4;

    // Clock select fields.
    localparam int unsigned TICK_SOURCE_SELECT_SRC_BIT  = 0;
    localparam int unsigned TICK_SOURCE_SELECT_LOCK_BIT = 31;

    // Reset values and the timeout constant floor.
    localparam logic [23:0] TC_RST        = 24'h0000FF;
    localparam logic [23:0] TC_MIN        = 24'h0000FF;
    localparam logic [23:0] WINDOW_RST    = 24'hFFFFFF;
    localparam logic [9:0]  WARN_RST      = 10'h000;

    // Feed keys.
    localparam logic [7:0]  FEED_KEY_1    = 8'hAA;
    localparam logic [7:0]  FEED_KEY_2    = 8'h55;

    // Tick clock rates; the oscillators are modelled as enables from a divider.
    localparam int unsigned RC_TICK_HZ    = 12_500_000;
    localparam int unsigned LP_TICK_HZ    = 500_000;
    localparam int unsigned RC_DIV        = CLK_HZ / RC_TICK_HZ;
    localparam int unsigned LP_DIV        = CLK_HZ / LP_TICK_HZ;
    localparam int unsigned DIV_W         = 16;
    localparam logic [1:0]  TICKS_PER_CNT_M1 = 2'h3;

    // Length of the chip reset pulse in peripheral clocks, minus one.
    localparam logic [3:0]  RST_PULSE_M1  = 4'hF;

    typedef enum logic [2:0] {
        WWD_R_NONE,
        WWD_R_MODE,
        WWD_R_TC,
        WWD_R_FEED,
        WWD_R_VALUE,
        WWD_R_TICK_SOURCE_SELECT,
        WWD_R_WARN,
        WWD_R_WINDOW
    } wwd_reg_t;

endpackage

/* verilog/wwd_top.sv */
/*
 * Windowed watchdog timer with a classic Wishbone register slave.
 * Assumes one 200 MHz clock, a synchronous active-high reset that is the
 * external reset, and a system that routes chip_reset_o to the chip reset.
 */
// Notes on behaviour
// - Run enable at 0 stops the counter; no warnings and no resets.
// - Interrupt mode sets the warning flag at warning match; resets only on a protect violation.
// - Reset mode also resets the chip at the next count step after the running counter reaches zero.
// - In reset mode a feed above the window compare resets instead of reloading.
// - Each completed feed loads the timeout constant, except a reset-mode window violation.
// - Timeout constant resets to 0xFF; writes below 0xFF store 0xFF.
// - Counter decrements once every four tick clock cycles.
// - Counter, constant and readback are 24 bits; upper bits reserved.
// - Protected constant write before counter is below both compares resets chip.
// - Run enable alone does not arm; first valid feed starts and arms it.
// - Before the first valid feed, malformed feed sequences are ignored.
// - After 0xAA, any other register access is a feed error.
// - Feed error reset is asserted in the second clock after the access.
// - Counter readback is a lagging resynchronised copy of the counter.
// - Clock select bit 0 picks RC (0) or low-power oscillator (1), resets 0.
// - While clock select bit 31 is set, writes leave bit 0 unchanged.
// - Warning flag is raised one tick clock after the warning match.
// - Warning match is low 10 counter bits equal compare, upper bits zero.
// - Warning compare 0 raises the warning with the timeout event.
// - Window compare resets to 0xFFFFFF; a feed above it is an event.
// - Run, reset enable and protect are sticky until reset.
// - Timeout flag set on any event, cleared by writing 0, survives own reset.
// - Run, reset enable and protect changes take effect only after the next valid feed.
`timescale 1ns/10ps

module wwd_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             warning_irq_o,
    output logic             chip_reset_o
);

    function automatic wwd_pkg::wwd_reg_t decode(input logic [31:0] adr);
        wwd_pkg::wwd_reg_t r;
        r = wwd_pkg::WWD_R_NONE;
        unique case (adr)
            wwd_pkg::ADR_MODE:   r = wwd_pkg::WWD_R_MODE;
            wwd_pkg::ADR_TC:     r = wwd_pkg::WWD_R_TC;
            wwd_pkg::ADR_FEED:   r = wwd_pkg::WWD_R_FEED;
            wwd_pkg::ADR_VALUE:  r = wwd_pkg::WWD_R_VALUE;
            wwd_pkg::ADR_TICK_SOURCE_SELECT: r = wwd_pkg::WWD_R_TICK_SOURCE_SELECT;
            wwd_pkg::ADR_WARN:   r = wwd_pkg::WWD_R_WARN;
            wwd_pkg::ADR_WINDOW: r = wwd_pkg::WWD_R_WINDOW;
            default:             r = wwd_pkg::WWD_R_NONE;
        endcase
        return r;
    endfunction

    // Byte-lane merge of a write into an old register value.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction

    logic                 ack_ff;
    logic [31:0]          rdat_ff;
    logic [23:0]          tc_ff;
    logic [23:0]          cnt_ff;
    logic [23:0]          rb_ff;
    logic [23:0]          window_ff;
    logic [9:0]           warn_ff;
    logic                 src_ff;
    logic                 lock_ff;
    logic                 run_pend_ff;
    logic                 rst_pend_ff;
    logic                 prot_pend_ff;
    logic                 run_act_ff;
    logic                 rst_act_ff;
    logic                 prot_act_ff;
    logic                 tof_ff;
    logic                 wflag_ff;
    logic                 key1_ff;
    logic                 evt_rst_ff;
    logic                 chip_reset_ff;
    logic [3:0]           hold_ff;
    logic [wwd_pkg::DIV_W-1:0] div_ff;
    logic                 tick_ff;
    logic [1:0]           pre_ff;
    logic                 match_pend_ff;

    logic                 take;
    logic                 wr;
    wwd_pkg::wwd_reg_t    reg_sel;
    logic                 mapped;
    logic [31:0]          wmode;
    logic                 feed_wr;
    logic                 feed_ok;
    logic                 feed_bad;
    logic                 feed_err;
    logic                 win_viol;
    logic                 prot_viol;
    logic                 quarter_en;
    logic                 timeout_ev;
    logic                 warn_match;
    logic                 soft_rst;
    logic [31:0]          tc_new;
    logic [31:0]          warn_new;
    logic [31:0]          win_new;
    logic [wwd_pkg::DIV_W-1:0] div_top;

    assign take     = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr       = take && wb_we_i;
    assign reg_sel  = decode(wb_adr_i);
    assign mapped   = (reg_sel != wwd_pkg::WWD_R_NONE);
    assign wmode    = merge(32'h0000_00FF, wb_dat_i, wb_sel_i);
    assign tc_new   = merge({8'h00, tc_ff}, wb_dat_i, wb_sel_i);
    assign warn_new = merge({22'h000000, warn_ff}, wb_dat_i, wb_sel_i);
    assign win_new  = merge({8'h00, window_ff}, wb_dat_i, wb_sel_i);
    // The own reset clears everything but the timeout flag, the reset pulse generator and the bus.
    assign soft_rst = rst_i || chip_reset_ff;

    // Feed decoding.
    assign feed_wr  = wr && (reg_sel == wwd_pkg::WWD_R_FEED) && wb_sel_i[0];
    assign feed_ok  = take && key1_ff && feed_wr
                      && (wb_dat_i[7:0] == wwd_pkg::FEED_KEY_2);
    assign feed_bad = take && key1_ff && mapped && !feed_ok;
    assign feed_err = feed_bad && run_act_ff;
    assign win_viol = feed_ok && run_act_ff && (cnt_ff > window_ff);
    // Writes are judged against the compares, whatever the byte lanes.
    // A stopped watchdog never resets the chip, so protection needs a running counter.
    assign prot_viol = wr && (reg_sel == wwd_pkg::WWD_R_TC) && prot_act_ff && run_act_ff
                       && !((cnt_ff < {14'h0000, warn_ff}) && (cnt_ff < window_ff));

    // Tick enable and quarter tick.
    assign div_top    = src_ff ? wwd_pkg::DIV_W'(wwd_pkg::LP_DIV - 1)
                               : wwd_pkg::DIV_W'(wwd_pkg::RC_DIV - 1);
    assign quarter_en = tick_ff && run_act_ff
                        && (pre_ff == wwd_pkg::TICKS_PER_CNT_M1);
    assign timeout_ev = quarter_en && (cnt_ff == 24'h000000);
    assign warn_match = (cnt_ff[9:0] == warn_ff) && (cnt_ff[23:10] == 14'h0000);

    // Wishbone answer: one cycle after the request is taken.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_ff <= 32'h0000_0000;
        end else if (take) begin
            rdat_ff <= 32'h0000_0000;
            unique case (reg_sel)
                wwd_pkg::WWD_R_MODE: begin
                    rdat_ff[wwd_pkg::MODE_RUN_BIT]  <= run_pend_ff;
                    rdat_ff[wwd_pkg::MODE_RST_BIT]  <= rst_pend_ff;
                    rdat_ff[wwd_pkg::MODE_TOF_BIT]  <= tof_ff;
                    rdat_ff[wwd_pkg::MODE_WINT_BIT] <= wflag_ff;
                    rdat_ff[wwd_pkg::MODE_PROT_BIT] <= prot_pend_ff;
                end
                wwd_pkg::WWD_R_TC:     rdat_ff <= {8'h00, tc_ff};
                wwd_pkg::WWD_R_VALUE:  rdat_ff <= {8'h00, rb_ff};
                wwd_pkg::WWD_R_TICK_SOURCE_SELECT: begin
                    rdat_ff[wwd_pkg::TICK_SOURCE_SELECT_SRC_BIT]  <= src_ff;
                    rdat_ff[wwd_pkg::TICK_SOURCE_SELECT_LOCK_BIT] <= lock_ff;
                end
                wwd_pkg::WWD_R_WARN:   rdat_ff <= {22'h000000, warn_ff};
                wwd_pkg::WWD_R_WINDOW: rdat_ff <= {8'h00, window_ff};
                wwd_pkg::WWD_R_FEED,
                wwd_pkg::WWD_R_NONE:   rdat_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Mode bits written by software; sticky until a reset.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            run_pend_ff  <= 1'b0;
            rst_pend_ff  <= 1'b0;
            prot_pend_ff <= 1'b0;
        end else if (wr && (reg_sel == wwd_pkg::WWD_R_MODE) && wb_sel_i[0]) begin
            run_pend_ff  <= run_pend_ff  | wmode[wwd_pkg::MODE_RUN_BIT];
            rst_pend_ff  <= rst_pend_ff  | wmode[wwd_pkg::MODE_RST_BIT];
            prot_pend_ff <= prot_pend_ff | wmode[wwd_pkg::MODE_PROT_BIT];
        end
    end

    // Active copies follow the written bits only at a valid feed.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            run_act_ff  <= 1'b0;
            rst_act_ff  <= 1'b0;
            prot_act_ff <= 1'b0;
        end else if (feed_ok) begin
            run_act_ff  <= run_pend_ff;
            rst_act_ff  <= rst_pend_ff;
            prot_act_ff <= prot_pend_ff;
        end
    end

    // Timeout constant, with a floor and write protection.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            tc_ff <= wwd_pkg::TC_RST;
        end else if (wr && (reg_sel == wwd_pkg::WWD_R_TC) && !prot_viol) begin
            if (tc_new[23:0] < wwd_pkg::TC_MIN) begin
                tc_ff <= wwd_pkg::TC_MIN;
            end else begin
                tc_ff <= tc_new[23:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            warn_ff   <= wwd_pkg::WARN_RST;
            window_ff <= wwd_pkg::WINDOW_RST;
        end else if (wr && (reg_sel == wwd_pkg::WWD_R_WARN)) begin
            warn_ff <= warn_new[9:0];
        end else if (wr && (reg_sel == wwd_pkg::WWD_R_WINDOW)) begin
            window_ff <= win_new[23:0];
        end
    end

    // Clock select with its lock bit.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            src_ff  <= 1'b0;
            lock_ff <= 1'b0;
        end else if (wr && (reg_sel == wwd_pkg::WWD_R_TICK_SOURCE_SELECT)) begin
            if (wb_sel_i[3]) begin
                lock_ff <= wb_dat_i[wwd_pkg::TICK_SOURCE_SELECT_LOCK_BIT];
            end
            if (wb_sel_i[0] && !lock_ff) begin
                src_ff <= wb_dat_i[wwd_pkg::TICK_SOURCE_SELECT_SRC_BIT];
            end
        end
    end

    // Tick clock enable from the selected oscillator divider.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff >= div_top) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (soft_rst || feed_ok) begin
            pre_ff <= 2'h0;
        end else if (tick_ff && run_act_ff) begin
            pre_ff <= pre_ff + 2'h1;
        end
    end

    // Counter: reload on feed, count down while running.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            cnt_ff <= wwd_pkg::TC_RST;
        end else if (feed_ok && !(win_viol && rst_act_ff)) begin
            cnt_ff <= tc_ff;
        end else if (quarter_en && (cnt_ff != 24'h000000)) begin
            cnt_ff <= cnt_ff - 24'h000001;
        end
    end

    // Readback copy is refreshed once per tick clock, so it lags the counter.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            rb_ff <= wwd_pkg::TC_RST;
        end else if (tick_ff) begin
            rb_ff <= cnt_ff;
        end
    end

    // First feed key seen; any following mapped register access ends the sequence.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            key1_ff <= 1'b0;
        end else if (take && mapped) begin
            if (key1_ff) begin
                key1_ff <= 1'b0;
            end else if (feed_wr && (wb_dat_i[7:0] == wwd_pkg::FEED_KEY_1)) begin
                key1_ff <= 1'b1;
            end
        end
    end

    // A match waits for the next tick clock before raising the warning.
    always_ff @(posedge clk_i) begin
        if (soft_rst || feed_ok) begin
            match_pend_ff <= 1'b0;
        end else if (quarter_en && (cnt_ff != 24'h000000)
                     && ((cnt_ff - 24'h000001) == {14'h0000, warn_ff})
                     && (warn_ff != 10'h000)) begin
            match_pend_ff <= 1'b1;
        end else if (tick_ff) begin
            match_pend_ff <= 1'b0;
        end
    end

    // Warning flag: set wins over a software clear.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            wflag_ff <= 1'b0;
        end else if ((match_pend_ff && tick_ff && run_act_ff)
                     || (timeout_ev && warn_match)
                     || ((feed_err || win_viol) && !rst_act_ff)) begin
            wflag_ff <= 1'b1;
        end else if (wr && (reg_sel == wwd_pkg::WWD_R_MODE) && wb_sel_i[0]
                     && !wb_dat_i[wwd_pkg::MODE_WINT_BIT]) begin
            wflag_ff <= 1'b0;
        end
    end

    // Timeout flag: survives the watchdog's own reset; set wins over clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tof_ff <= 1'b0;
        end else if (timeout_ev || feed_err || win_viol || prot_viol) begin
            tof_ff <= 1'b1;
        end else if (wr && (reg_sel == wwd_pkg::WWD_R_MODE) && wb_sel_i[0]
                     && !wb_dat_i[wwd_pkg::MODE_TOF_BIT]) begin
            tof_ff <= 1'b0;
        end
    end

    // Reset request is staged one clock so the pin rises in the second clock.
    always_ff @(posedge clk_i) begin
        if (soft_rst) begin
            evt_rst_ff <= 1'b0;
        end else begin
            evt_rst_ff <= (rst_act_ff && (timeout_ev || feed_err || win_viol))
                          || prot_viol;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chip_reset_ff <= 1'b0;
            hold_ff       <= 4'h0;
        end else if (evt_rst_ff) begin
            chip_reset_ff <= 1'b1;
            hold_ff       <= wwd_pkg::RST_PULSE_M1;
        end else if (hold_ff != 4'h0) begin
            hold_ff <= hold_ff - 4'h1;
        end else begin
            chip_reset_ff <= 1'b0;
        end
    end

    assign wb_ack_o      = ack_ff;
    assign wb_dat_o      = rdat_ff;
    assign warning_irq_o = wflag_ff;
    assign chip_reset_o  = chip_reset_ff;

endmodule

/* sim/wwd_top_asserts.sv */
/*
 * Checker for wwd_top: bus answer, read-back masks and output pulses.
 * Assumes one clock and the synchronous active-high reset rst_i.
 */
`timescale 1ns/10ps
module wwd_chk (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        warning_irq_o,
    input  wire logic        chip_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic tk;
    logic rd;
    logic run_ff;
    assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd = tk && !wb_we_i;
    // Only a reset clears this, so it stays conservative after an own chip reset.
    always_ff @(posedge clk_i) begin
        if (rst_i)
            run_ff <= 1'b0;
        else if (tk && wb_we_i && wb_adr_i == wwd_pkg::ADR_MODE && wb_dat_i[0])
            run_ff <= 1'b1;
    end
    property p_ack_resp; tk |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_idle; !run_ff |-> !chip_reset_o && !warning_irq_o; endproperty
    a_idle: assert property (p_idle) else $error("event while stopped");
    property p_pulse; $rose(chip_reset_o) |-> ##15 chip_reset_o ##1 !chip_reset_o; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse length");
    property p_feed_rd; rd && wb_adr_i == wwd_pkg::ADR_FEED |=> wb_dat_o == 32'h0; endproperty
    a_feed_rd: assert property (p_feed_rd) else $error("feed reads nonzero");
    property p_unmap; rd && wb_adr_i > wwd_pkg::ADR_WINDOW |=> wb_dat_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped nonzero");
    property p_wide;
        rd && (wb_adr_i == wwd_pkg::ADR_TC || wb_adr_i == wwd_pkg::ADR_VALUE)
        |=> wb_dat_o[31:24] == 8'h00;
    endproperty
    a_wide: assert property (p_wide) else $error("reserved bits set");
    property p_warn; rd && wb_adr_i == wwd_pkg::ADR_WARN |=> wb_dat_o[31:10] == 22'h0; endproperty
    a_warn: assert property (p_warn) else $error("warn field too wide");
    property p_tcmin; rd && wb_adr_i == wwd_pkg::ADR_TC |=> wb_dat_o[23:0] >= 24'h0000FF; endproperty
    a_tcmin: assert property (p_tcmin) else $error("constant below floor");
    property p_wclr;
        $fell(warning_irq_o) |-> chip_reset_o || $past(chip_reset_o)
        || $past(tk && wb_we_i && wb_adr_i == wwd_pkg::ADR_MODE && !wb_dat_i[3]);
    endproperty
    a_wclr: assert property (p_wclr) else $error("warning flag lost");
    c_rst: cover property ($rose(chip_reset_o));
    c_irq: cover property ($rose(warning_irq_o));
    c_feed: cover property (rd && wb_adr_i == wwd_pkg::ADR_FEED);
endmodule
bind wwd_top wwd_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .warning_irq_o(warning_irq_o),
    .chip_reset_o(chip_reset_o));

/* sim/wwd_tb.sv */
/*
 * Self-checking bench for wwd_top: registers, feeds, modes and timing.
 * Assumes the register map and tick divider of wwd_pkg.
 */
`timescale 1ns/10ps
module testbench;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        warning_irq_o, chip_reset_o, rst_neg;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd_v, wd;
    logic [23:0] tc_m;
    int          err_count = 0, checks_done = 0, cyc_n = 0, n, ex;

    wwd_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .warning_irq_o(warning_irq_o),
        .chip_reset_o(chip_reset_o));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Mid-cycle copy of the reset pin, so the cycle before an edge can be judged.
    always @(negedge clk_i) rst_neg = chip_reset_o;

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 60000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // The request stands until ack is sampled high; read data is taken at that edge.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd_v = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic feed();
        wr(wwd_pkg::ADR_FEED, 32'h0000_00AA);
        wr(wwd_pkg::ADR_FEED, 32'h0000_0055);
    endtask

    task automatic wait_rst(input int lim);
        n = 0;
        while (chip_reset_o !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    function automatic logic [31:0] inr(input int v, input int lo, input int hi);
        return {31'h0, v >= lo && v <= hi};
    endfunction

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 32'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hF;
        wd = $urandom(79);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(wwd_pkg::ADR_TC);
        chk("tc", 32'h0000_00FF, rd_v);
        rd(wwd_pkg::ADR_VALUE);
        chk("value", 32'h0000_00FF, rd_v);
        rd(wwd_pkg::ADR_TICK_SOURCE_SELECT);
        chk("tick_source_select", 32'h0, rd_v);
        rd(wwd_pkg::ADR_WARN);
        chk("warn", 32'h0, rd_v);
        rd(wwd_pkg::ADR_WINDOW);
        chk("window", 32'h00FF_FFFF, rd_v);
        rd(wwd_pkg::ADR_FEED);
        chk("feed", 32'h0, rd_v);
        rd(32'h4000_401C);
        chk("unmapped", 32'h0, rd_v);
        for (int i = 0; i < 8; i++) begin
            wd = (i == 0) ? 32'h0000_00FE : $urandom & ((i % 2) ? 32'h1FF : 32'hFFFF_FFFF);
            tc_m = (wd[23:0] < 24'h0000FF) ? 24'h0000FF : wd[23:0];
            wr(wwd_pkg::ADR_TC, wd);
            rd(wwd_pkg::ADR_TC);
            chk("tc store", {8'h0, tc_m}, rd_v);
        end
        wr(wwd_pkg::ADR_TICK_SOURCE_SELECT, 32'h8000_0000);
        wr(wwd_pkg::ADR_TICK_SOURCE_SELECT, 32'h8000_0001);
        rd(wwd_pkg::ADR_TICK_SOURCE_SELECT);
        chk("tick_source_select locked", 32'h0, {31'h0, rd_v[0]});
        wr(wwd_pkg::ADR_TICK_SOURCE_SELECT, 32'h0);
        wr(wwd_pkg::ADR_TICK_SOURCE_SELECT, 32'h1);
        rd(wwd_pkg::ADR_TICK_SOURCE_SELECT);
        chk("tick_source_select src", 32'h1, {31'h0, rd_v[0]});
        wr(wwd_pkg::ADR_TICK_SOURCE_SELECT, 32'h0);
        wr(wwd_pkg::ADR_FEED, 32'h0000_00AA);
        rd(wwd_pkg::ADR_TC);
        wait_rst(40);
        chk("stopped", 32'h0, {31'h0, chip_reset_o});
        wr(wwd_pkg::ADR_WARN, 32'h0000_00F0);
        wr(wwd_pkg::ADR_TC, 32'h0000_0100);
        wr(wwd_pkg::ADR_MODE, 32'h1);
        feed();
        repeat (320) @(posedge clk_i);
        rd(wwd_pkg::ADR_VALUE);
        chk("readback", 32'h1, inr(rd_v, 32'hF9, 32'h100));
        n = 0;
        while (warning_irq_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        ex = 16 * 4 * wwd_pkg::RC_DIV + wwd_pkg::RC_DIV - 325;
        chk("warn delay", 32'h1, inr(n, ex - 128, ex + 128));
        wait_rst(16500);
        chk("no reset", 32'h0, {31'h0, chip_reset_o});
        wr(wwd_pkg::ADR_MODE, 32'h3);
        feed();
        chk("warn clear", 32'h0, {31'h0, warning_irq_o});
        wr(wwd_pkg::ADR_MODE, 32'h0);
        rd(wwd_pkg::ADR_MODE);
        chk("sticky", 32'h3, {30'h0, rd_v[1:0]});
        wr(wwd_pkg::ADR_FEED, 32'h0000_00AA);
        rd(wwd_pkg::ADR_TC);
        chk("err rst early", 32'h0, {31'h0, rst_neg});
        #1 chk("err rst", 32'h1, {31'h0, chip_reset_o});
        repeat (24) @(posedge clk_i);
        rd(wwd_pkg::ADR_MODE);
        chk("flag kept", 32'h4, rd_v);
        wr(wwd_pkg::ADR_MODE, 32'h0);
        rd(wwd_pkg::ADR_MODE);
        chk("flag clear", 32'h0, rd_v);
        wr(wwd_pkg::ADR_MODE, 32'h3);
        wr(wwd_pkg::ADR_FEED, 32'h0000_00AA);
        rd(wwd_pkg::ADR_TC);
        wait_rst(40);
        chk("unarmed", 32'h0, {31'h0, chip_reset_o});
        feed();
        wr(wwd_pkg::ADR_WINDOW, 32'h0000_0080);
        feed();
        wait_rst(60);
        chk("window rst", 32'h1, {31'h0, chip_reset_o});
        repeat (24) @(posedge clk_i);
        wr(wwd_pkg::ADR_MODE, 32'h13);
        feed();
        wr(wwd_pkg::ADR_TC, 32'h0000_0200);
        wait_rst(60);
        chk("protect rst", 32'h1, {31'h0, chip_reset_o});
        repeat (24) @(posedge clk_i);
        rd(wwd_pkg::ADR_TC);
        chk("protect tc", 32'h0000_00FF, rd_v);
        wr(wwd_pkg::ADR_MODE, 32'h3);
        feed();
        wait_rst(20000);
        chk("warn at timeout", 32'h1, {31'h0, warning_irq_o});
        ex = 256 * 4 * wwd_pkg::RC_DIV;
        chk("timeout", 32'h1, inr(n, ex - 128, ex + 128));
        summarize();
    end
endmodule
